// [inc/iap_pkg.sv]
// Package for the acknowledge policy block: constants, enums and carrier structs.
// Assumes a single 100 MHz core clock and a synchronous active-high reset.
`default_nettype none
package iap_pkg;
  localparam int unsigned IAP_CNT_W = 7;
  localparam logic [6:0] IAP_CNT_MAX = 7'h44;
  localparam logic [6:0] IAP_CNT_ZERO = 7'h00;
  localparam logic [6:0] IAP_CNT_ONE = 7'h01;
  localparam logic [7:0] IAP_STAT_BAD_CNT = 8'hFC;
  localparam logic [7:0] IAP_STAT_IDLE = 8'hF8;

  // Role of the device during the current bus message.
  typedef enum logic [1:0] {
    IAP_ROLE_MASTER_RX = 2'h0,
    IAP_ROLE_MASTER_TX = 2'h1,
    IAP_ROLE_SLAVE_RX = 2'h3,
    IAP_ROLE_SLAVE_TX = 2'h2
  } iap_role_t;

  // Sequence state: Gray coded along idle, addressed, data.
  typedef enum logic [1:0] {
    IAP_ST_IDLE = 2'h0,
    IAP_ST_ADDR = 2'h1,
    IAP_ST_DATA = 2'h3,
    IAP_ST_DONE = 2'h2
  } iap_state_t;

  // Control settings presented by the host.
  typedef struct packed {
    logic ack_assert;
    logic general_call_enable;
    logic last_byte_nack;
    logic buffered;
    logic [6:0] buffer_byte_count;
  } iap_ctrl_t;

  // Bus events reported by the serial engine.
  typedef struct packed {
    logic start_seen;
    logic stop_seen;
    logic own_addr_match;
    logic gc_addr_match;
    logic ack_slot;
    logic addr_phase;
    iap_role_t role;
  } iap_bus_t;
endpackage
`default_nettype wire

// [hw/iap_count_check.sv]
// Byte count validity check for buffered sequences.
// Assumes the control write strobe is a one-cycle pulse.
`default_nettype none
module iap_count_check
  import iap_pkg::*;
(
  input wire logic core_clk, // Core clock.
  input wire logic srst, // Synchronous reset.
  input wire logic clk_en, // Clock enable.
  input wire logic ctrl_write, // Control write pulse.
  input wire logic buffered, // Buffered mode selected.
  input wire logic [6:0] count, // Requested byte count.
  output logic bad_count, // Registered invalid-count pulse.
  output logic count_ok // Combinational validity of the count.
);
  logic next_bad_count;

  ////////////////////////////////////////////////////////////////////////
  // Zero or more than the buffer depth cannot be served.
  always_comb begin
    count_ok = (count != IAP_CNT_ZERO) && (count <= IAP_CNT_MAX);
    next_bad_count = ctrl_write && buffered && !count_ok;
  end

  // Registered so the status load and interrupt align with each other.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bad_count <= 1'b0;
    end else if (clk_en) begin
      bad_count <= next_bad_count;
    end
  end

  a_bad_count_pulse: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && ctrl_write && buffered && (count == IAP_CNT_ZERO || count > IAP_CNT_MAX)
    |=> bad_count)
    else $error("invalid count not flagged");
endmodule
`default_nettype wire

// [hw/iap_byte_counter.sv]
// Counts acknowledged data bytes of a buffered sequence.
// Assumes ack slot pulses are single cycles from the serial engine.
`default_nettype none
module iap_byte_counter
  import iap_pkg::*;
(
  input wire logic core_clk, // Core clock.
  input wire logic srst, // Synchronous reset.
  input wire logic clk_en, // Clock enable.
  input wire logic clear, // Restart counting.
  input wire logic step, // One data byte acknowledged slot passed.
  input wire logic [6:0] target, // Programmed byte count.
  output logic [6:0] done_bytes, // Bytes seen so far.
  output logic is_last, // Next byte is the final counted one.
  output logic exhausted // Count reached.
);
  logic [6:0] next_done_bytes;

  ////////////////////////////////////////////////////////////////////////
  // Counter saturates at the target so stray slots cannot wrap it.
  always_comb begin
    // Flags first, so the step below never reads a stale exhausted value.
    is_last = (done_bytes + IAP_CNT_ONE) == target;
    exhausted = done_bytes >= target;
    next_done_bytes = done_bytes;
    if (clear) begin
      next_done_bytes = IAP_CNT_ZERO;
    end else if (step && !exhausted) begin
      next_done_bytes = done_bytes + IAP_CNT_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      done_bytes <= IAP_CNT_ZERO;
    end else if (clk_en) begin
      done_bytes <= next_done_bytes;
    end
  end
endmodule
`default_nettype wire

// [hw/iap_ack_policy.sv]
// Acknowledge decision logic for a two-wire bus controller.
// Assumes a serial engine that reports address matches and ack slots.
// Overview of operation
// - Byte-by-byte policy without buffering, sequence policy with buffering.
// - Own address and General Call address acknowledged independently.
// - Master receiver unbuffered, ack_assert low: NACK every byte.
// - Master receiver unbuffered, ack_assert high: ACK every byte.
// - Master receiver buffered, last_byte_nack low: ACK all counted bytes.
// - Master receiver buffered, last_byte_nack high: NACK only final counted byte.
// - Master transmitter unbuffered sends one byte at a time.
// - ack_assert low unbuffered: NACK own address and slave data.
// - ack_assert high unbuffered: ACK own address and slave data.
// - Unbuffered slave transmitter drops to not-addressed when ack_assert clears.
// - Slave transmitter stays addressed while ack_assert is high.
// - Buffered own address: data ACK to count, address follows ack_assert.
// - Buffered General Call with last_byte_nack: NACK final byte only.
// - No last-byte NACK when STOP arrives before the final byte.
// - General Call disabled: NACK address and data; enabled: ACK address, unbuffered data follows ack_assert.
// - Slave data policy applies only to bytes after matching address.
// - Invalid buffered count: no transfer, interrupt, status code loaded.
`default_nettype none
module iap_ack_policy
  import iap_pkg::*;
(
  input wire logic core_clk, // Core clock.
  input wire logic srst, // Synchronous reset.
  input wire logic clk_en, // Clock enable.
  input wire iap_ctrl_t ctrl, // Control settings.
  input wire logic ctrl_write, // Control write pulse.
  input wire iap_bus_t bus, // Bus events.
  output logic ack_valid, // Decision valid, one-cycle pulse.
  output logic ack_drive, // 1 = ACK, 0 = NACK, registered.
  output logic addressed, // Device is an addressed slave.
  output logic byte_at_once, // Single-byte transfer step.
  output logic transfer_enable, // Buffered transfer may run.
  output logic irq, // Invalid count interrupt.
  output logic [7:0] status_code, // Status code.
  output logic [6:0] bytes_done // Bytes handled in sequence.
);
  iap_state_t state, next_state;
  logic gc_msg, next_gc_msg;
  logic next_ack_valid, next_ack_drive, next_addressed, next_irq;
  logic [7:0] next_status_code;
  logic next_transfer_enable;
  logic decide;
  logic bad_count, count_ok, is_last, exhausted, step;
  logic is_slave, is_master_rx;

  ////////////////////////////////////////////////////////////////////////
  // Helper blocks.
  iap_count_check u_check (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .ctrl_write(ctrl_write),
    .buffered(ctrl.buffered),
    .count(ctrl.buffer_byte_count),
    .bad_count(bad_count),
    .count_ok(count_ok)
  );

  iap_byte_counter u_cnt (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .clear(bus.start_seen || bus.stop_seen),
    .step(step),
    .target(ctrl.buffer_byte_count),
    .done_bytes(bytes_done),
    .is_last(is_last),
    .exhausted(exhausted)
  );

  ////////////////////////////////////////////////////////////////////////
  // Role decode; a transmitter decides no data ack, it sends bytes; a slave transmitter decides its address ack.
  assign is_slave = (bus.role == IAP_ROLE_SLAVE_RX) || (bus.role == IAP_ROLE_SLAVE_TX);
  assign is_master_rx = bus.role == IAP_ROLE_MASTER_RX;
  assign byte_at_once = !ctrl.buffered;
  assign decide = bus.ack_slot && (is_master_rx || bus.role == IAP_ROLE_SLAVE_RX ||
                  (bus.addr_phase && is_slave));
  assign step = bus.ack_slot && !bus.addr_phase && ctrl.buffered && (state == IAP_ST_DATA);

  ////////////////////////////////////////////////////////////////////////
  // Decision, sequence state and status; controls sampled at the slot start.
  always_comb begin
    next_state = state;
    next_gc_msg = gc_msg;
    next_ack_valid = 1'b0;
    next_ack_drive = ack_drive;
    next_addressed = addressed;
    next_irq = 1'b0;
    next_status_code = status_code;
    next_transfer_enable = transfer_enable;
    if (ctrl_write) begin
      next_transfer_enable = !ctrl.buffered || count_ok;
    end
    if (bad_count) begin
      next_irq = 1'b1;
      next_status_code = IAP_STAT_BAD_CNT;
    end
    // A new message forgets the General Call mark of the one before it.
    if (bus.start_seen) begin
      next_gc_msg = 1'b0;
    end
    case (state)
      IAP_ST_IDLE: begin
        next_addressed = 1'b0;
        if (bus.start_seen) begin
          next_state = IAP_ST_ADDR;
        end
      end
      IAP_ST_ADDR: begin
        if (bus.stop_seen) begin
          next_state = IAP_ST_IDLE;
        end else if (decide && bus.addr_phase && is_slave) begin
          next_ack_valid = 1'b1;
          next_gc_msg = bus.gc_addr_match && !bus.own_addr_match;
          if (bus.own_addr_match) begin
            next_ack_drive = ctrl.ack_assert;
          end else if (bus.gc_addr_match) begin
            next_ack_drive = ctrl.general_call_enable;
          end else begin
            next_ack_drive = 1'b0;
          end
          next_addressed = next_ack_drive;
          next_state = next_ack_drive ? IAP_ST_DATA : IAP_ST_DONE;
        end else if (decide && is_master_rx && !bus.addr_phase) begin
          next_state = IAP_ST_DATA;
        end else if (bus.ack_slot && bus.addr_phase && !is_slave) begin
          next_state = IAP_ST_DATA;
        end
      end
      IAP_ST_DATA: begin
        if (bus.stop_seen) begin
          next_state = IAP_ST_IDLE;
        end else if (bus.start_seen) begin
          next_state = IAP_ST_ADDR;
        end else if (bus.role == IAP_ROLE_SLAVE_TX && !ctrl.ack_assert && !ctrl.buffered) begin
          next_addressed = 1'b0;
          next_state = IAP_ST_DONE;
        end else if (decide && !bus.addr_phase) begin
          next_ack_valid = 1'b1;
          if (is_slave && gc_msg && !ctrl.general_call_enable) begin
            next_ack_drive = 1'b0;
          end else if (!ctrl.buffered) begin
            next_ack_drive = ctrl.ack_assert;
          end else if (exhausted) begin
            next_ack_drive = 1'b0;
          end else begin
            next_ack_drive = !(ctrl.last_byte_nack && is_last);
          end
        end
        // Slave transmitter with ack_assert high keeps addressed until the end.
        if (bus.role == IAP_ROLE_SLAVE_TX && ctrl.ack_assert) begin
          next_addressed = 1'b1;
        end
      end
      IAP_ST_DONE: begin
        next_addressed = 1'b0;
        if (bus.stop_seen) begin
          next_state = IAP_ST_IDLE;
        end else if (bus.start_seen) begin
          next_state = IAP_ST_ADDR;
        end
      end
      default: begin
        next_state = IAP_ST_IDLE;
      end
    endcase
    if (!is_slave && state != IAP_ST_IDLE) begin
      next_addressed = 1'b0;
    end
  end

  // State registers only; clk_en freezes everything.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= IAP_ST_IDLE;
      gc_msg <= 1'b0;
      ack_valid <= 1'b0;
      ack_drive <= 1'b0;
      addressed <= 1'b0;
      irq <= 1'b0;
      status_code <= IAP_STAT_IDLE;
      transfer_enable <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      gc_msg <= next_gc_msg;
      ack_valid <= next_ack_valid;
      ack_drive <= next_ack_drive;
      addressed <= next_addressed;
      irq <= next_irq;
      status_code <= next_status_code;
      transfer_enable <= next_transfer_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks beside the logic they guard.
  // Many antecedents exclude stop, and in the data state start too, which take priority in the state logic.
  a_mrx_nack_unbuf: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_DATA && decide && !bus.addr_phase && is_master_rx &&
    !ctrl.buffered && !ctrl.ack_assert && !bus.stop_seen && !bus.start_seen
    |=> ack_valid && !ack_drive)
    else $error("master rx byte not nacked");

  a_mrx_ack_unbuf: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_DATA && decide && !bus.addr_phase && is_master_rx &&
    !ctrl.buffered && ctrl.ack_assert && !bus.stop_seen && !bus.start_seen
    |=> ack_valid && ack_drive)
    else $error("master rx byte not acked");

  a_buf_last_nack: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_DATA && decide && !bus.addr_phase && ctrl.buffered &&
    ctrl.last_byte_nack && is_last && !gc_msg && !bus.stop_seen && !bus.start_seen
    |=> !ack_drive)
    else $error("final counted byte acked");

  a_buf_mid_ack: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_DATA && decide && !bus.addr_phase && ctrl.buffered &&
    !ctrl.last_byte_nack && !exhausted && !gc_msg && !bus.stop_seen && !bus.start_seen
    |=> ack_drive)
    else $error("counted byte nacked");

  a_own_addr_ack: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_ADDR && decide && bus.addr_phase && is_slave &&
    bus.own_addr_match && !bus.stop_seen |=> ack_drive == $past(ctrl.ack_assert))
    else $error("own address ack wrong");

  a_gc_disabled: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_ADDR && decide && bus.addr_phase && is_slave &&
    bus.gc_addr_match && !bus.own_addr_match && !ctrl.general_call_enable &&
    !bus.stop_seen |=> !ack_drive ##0 !addressed)
    else $error("general call acked while disabled");

  a_stop_ends_seq: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && bus.stop_seen && state == IAP_ST_DATA
    |=> state == IAP_ST_IDLE ##0 !ack_valid)
    else $error("stop did not end sequence");

  a_bad_cnt_irq: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && bad_count |=> irq && status_code == IAP_STAT_BAD_CNT)
    else $error("invalid count not reported");

  // Slave transmitter fall-back and hold; the engine finishes the byte on its own.
  a_slv_tx_fallback: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_DATA && bus.role == IAP_ROLE_SLAVE_TX && !ctrl.ack_assert &&
    !ctrl.buffered && !bus.stop_seen && !bus.start_seen
    |=> state == IAP_ST_DONE && !addressed)
    else $error("slave transmitter did not fall back");

  a_slv_tx_stays: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_DATA && bus.role == IAP_ROLE_SLAVE_TX && ctrl.ack_assert &&
    !bus.stop_seen && !bus.start_seen |=> addressed)
    else $error("slave transmitter left addressed state");

  a_slv_data_unbuf: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_DATA && decide && !bus.addr_phase && is_slave && !gc_msg &&
    !ctrl.buffered && !bus.stop_seen && !bus.start_seen
    |=> ack_valid && ack_drive == $past(ctrl.ack_assert))
    else $error("slave data ack wrong");

  a_gc_data_follow: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_DATA && decide && !bus.addr_phase && is_slave && gc_msg &&
    ctrl.general_call_enable && !ctrl.buffered && !bus.stop_seen && !bus.start_seen
    |=> ack_valid && ack_drive == $past(ctrl.ack_assert))
    else $error("general call data ack wrong");

  a_gc_addr_ack: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_ADDR && decide && bus.addr_phase && is_slave &&
    bus.gc_addr_match && !bus.own_addr_match && ctrl.general_call_enable &&
    !bus.stop_seen |=> ack_valid && ack_drive && addressed)
    else $error("enabled general call not acked");

  a_gc_mark_clear: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && bus.start_seen && !bus.ack_slot |=> !gc_msg)
    else $error("general call mark survived a new start");

  a_own_nack_done: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_ADDR && decide && bus.addr_phase && is_slave &&
    bus.own_addr_match && !ctrl.ack_assert && !bus.stop_seen
    |=> state == IAP_ST_DONE && !addressed)
    else $error("refused address kept the message");

  a_done_silent: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_DONE |=> !ack_valid)
    else $error("decision made for an unaddressed message");

  a_maddr_no_decide: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_ADDR && bus.ack_slot && bus.addr_phase && !is_slave &&
    !bus.stop_seen |=> !ack_valid && state == IAP_ST_DATA)
    else $error("master address slot misread");

  a_mtx_no_decide: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state == IAP_ST_DATA && bus.ack_slot && !bus.addr_phase &&
    bus.role == IAP_ROLE_MASTER_TX |=> !ack_valid)
    else $error("transmitter byte produced a decision");

  a_cnt_clr_stop: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && bus.stop_seen |=> bytes_done == IAP_CNT_ZERO)
    else $error("stop did not restart the byte count");

  // A low clock enable must leave state, ack_drive, addressed, transfer_enable, status_code and bytes_done as they were.
  a_freeze_hold: assert property (@(posedge core_clk) disable iff (srst)
    !clk_en |=> $stable(state) && $stable(ack_drive) && $stable(addressed) &&
    $stable(transfer_enable) && $stable(status_code) && $stable(bytes_done))
    else $error("state moved while clock enable was low");
endmodule
`default_nettype wire

// [verification/iap_bus_model.sv]
// Stand-in for the serial engine and the far party on the two-wire bus.
// Assumes its tasks are called one at a time from the bench, at a falling edge.
`default_nettype none
module iap_bus_model
  import iap_pkg::*;
(
  input wire logic core_clk, // Core clock.
  output var iap_bus_t bus // Bus events towards the policy block.
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet bus until the first message opens.
  initial begin
    bus = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // A message opens with a start pulse and the role held for its whole length.
  task automatic start_msg(input iap_role_t r);
    bus.role = r;
    bus.start_seen = 1'b1;
    @(negedge core_clk);
    bus.start_seen = 1'b0;
  endtask

  // Stop pulse, then one quiet cycle so a new start never abuts it.
  task automatic stop_msg();
    bus.stop_seen = 1'b1;
    @(negedge core_clk);
    bus.stop_seen = 1'b0;
    bus.own_addr_match = 1'b0;
    bus.gc_addr_match = 1'b0;
    @(negedge core_clk);
  endtask

  // One acknowledge slot; data slots follow the matching address slot.
  task automatic slot(input logic a, input logic own, input logic gc);
    bus.addr_phase = a;
    bus.own_addr_match = own;
    bus.gc_addr_match = gc;
    bus.ack_slot = 1'b1;
    @(negedge core_clk);
    bus.ack_slot = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/iap_ack_policy_tb_top.sv]
// Self-checking bench for the acknowledge policy block.
// Assumes the bus model drives the event struct; the bench drives controls.
`default_nettype none
module iap_ack_policy_tb_top
  import iap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk;
  logic srst;
  logic clk_en;
  iap_ctrl_t ctrl;
  logic ctrl_write;
  iap_bus_t bus;
  logic ack_valid;
  logic ack_drive;
  logic addressed;
  logic byte_at_once;
  logic transfer_enable;
  logic irq;
  logic [7:0] status_code;
  logic [6:0] bytes_done;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  iap_bus_model u_bus (.core_clk(core_clk), .bus(bus));
  iap_ack_policy dut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .ctrl(ctrl),
    .ctrl_write(ctrl_write), .bus(bus), .ack_valid(ack_valid), .ack_drive(ack_drive),
    .addressed(addressed), .byte_at_once(byte_at_once), .transfer_enable(transfer_enable),
    .irq(irq), .status_code(status_code), .bytes_done(bytes_done));

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock and a hang guard well above the run length.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  // Compare tasks; an unknown never passes for a match.
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  // Poll a few cycles, since the decision lands one edge after the slot.
  task automatic check_ack(input logic ev, input logic ed);
    logic seen;
    logic drv;
    seen = 1'b0;
    drv = 1'b0;
    repeat (3) begin
      if (ack_valid === 1'b1) begin
        seen = 1'b1;
        drv = ack_drive;
      end
      @(negedge core_clk);
    end
    check_bit(seen, ev);
    if (ev) check_bit(drv, ed);
  endtask

  // Host control write: settings and a one-cycle strobe.
  task automatic set_ctrl(input logic aa, input logic gce, input logic lb, input logic bm,
                          input logic [6:0] cnt);
    ctrl = '{aa, gce, lb, bm, cnt};
    ctrl_write = 1'b1;
    @(negedge core_clk);
    ctrl_write = 1'b0;
    @(negedge core_clk);
  endtask

  // Count-check answer: irq pulse seen or not within a short window.
  task automatic check_irq(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (3) begin
      if (irq === 1'b1) seen = 1'b1;
      @(negedge core_clk);
    end
    check_bit(seen, exp);
  endtask

  // Start, address slot, then n data slots; bit i of dv and dd covers data byte i.
  task automatic run(input iap_role_t r, input logic own, input logic gc, input logic av,
                     input logic ad, input int n, input logic [7:0] dv, input logic [7:0] dd);
    u_bus.start_msg(r);
    u_bus.slot(1'b1, own, gc);
    check_ack(av, ad);
    for (int i = 0; i < n; i++) begin
      u_bus.slot(1'b0, own, gc);
      check_ack(dv[i], dd[i]);
    end
  endtask

  task automatic report_and_stop();
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; inputs change only at falling edges.
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    ctrl = '0;
    ctrl_write = 1'b0;
    repeat (16) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    check_byte(status_code, IAP_STAT_IDLE);
    // Unbuffered slave receiver on its own address, both ack_assert levels.
    set_ctrl(1'b1, 1'b0, 1'b0, 1'b0, 7'h00);
    check_bit(byte_at_once, 1'b1);
    run(IAP_ROLE_SLAVE_RX, 1'b1, 1'b0, 1'b1, 1'b1, 2, 8'h03, 8'h03);
    u_bus.stop_msg();
    set_ctrl(1'b0, 1'b1, 1'b0, 1'b0, 7'h00);
    run(IAP_ROLE_SLAVE_RX, 1'b1, 1'b0, 1'b1, 1'b0, 1, 8'h00, 8'h00);
    u_bus.stop_msg();
    // General Call address: disabled, enabled with each ack_assert level.
    set_ctrl(1'b1, 1'b0, 1'b0, 1'b0, 7'h00);
    run(IAP_ROLE_SLAVE_RX, 1'b0, 1'b1, 1'b1, 1'b0, 1, 8'h00, 8'h00);
    u_bus.stop_msg();
    set_ctrl(1'b0, 1'b1, 1'b0, 1'b0, 7'h00);
    run(IAP_ROLE_SLAVE_RX, 1'b0, 1'b1, 1'b1, 1'b1, 2, 8'h03, 8'h00);
    u_bus.stop_msg();
    set_ctrl(1'b1, 1'b1, 1'b0, 1'b0, 7'h00);
    run(IAP_ROLE_SLAVE_RX, 1'b0, 1'b1, 1'b1, 1'b1, 2, 8'h03, 8'h03);
    u_bus.stop_msg();
    // Unbuffered master: the address slot gives no decision of its own.
    set_ctrl(1'b0, 1'b1, 1'b1, 1'b0, 7'h00);
    run(IAP_ROLE_MASTER_RX, 1'b0, 1'b0, 1'b0, 1'b0, 2, 8'h03, 8'h00);
    u_bus.stop_msg();
    set_ctrl(1'b1, 1'b0, 1'b1, 1'b0, 7'h00);
    run(IAP_ROLE_MASTER_RX, 1'b0, 1'b0, 1'b0, 1'b0, 2, 8'h03, 8'h03);
    u_bus.stop_msg();
    run(IAP_ROLE_MASTER_TX, 1'b0, 1'b0, 1'b0, 1'b0, 2, 8'h00, 8'h00);
    u_bus.stop_msg();
    // Slave transmitter stays addressed until ack_assert is cleared mid-transfer.
    run(IAP_ROLE_SLAVE_TX, 1'b1, 1'b0, 1'b1, 1'b1, 1, 8'h00, 8'h00);
    check_bit(addressed, 1'b1);
    set_ctrl(1'b0, 1'b0, 1'b0, 1'b0, 7'h00);
    check_bit(addressed, 1'b0);
    u_bus.stop_msg();
    // Buffered write at the largest legal count, then sequences at short counts.
    set_ctrl(1'b0, 1'b0, 1'b0, 1'b1, IAP_CNT_MAX);
    check_irq(1'b0);
    check_bit(transfer_enable, 1'b1);
    check_bit(byte_at_once, 1'b0);
    set_ctrl(1'b0, 1'b0, 1'b0, 1'b1, 7'h03);
    run(IAP_ROLE_MASTER_RX, 1'b0, 1'b0, 1'b0, 1'b0, 3, 8'h07, 8'h07);
    check_byte({1'b0, bytes_done}, 8'h03);
    u_bus.stop_msg();
    set_ctrl(1'b1, 1'b0, 1'b1, 1'b1, 7'h03);
    run(IAP_ROLE_MASTER_RX, 1'b0, 1'b0, 1'b0, 1'b0, 3, 8'h07, 8'h03);
    u_bus.stop_msg();
    set_ctrl(1'b1, 1'b0, 1'b0, 1'b1, 7'h02);
    run(IAP_ROLE_SLAVE_RX, 1'b1, 1'b0, 1'b1, 1'b1, 2, 8'h03, 8'h03);
    u_bus.stop_msg();
    set_ctrl(1'b0, 1'b1, 1'b1, 1'b1, 7'h02);
    run(IAP_ROLE_SLAVE_RX, 1'b0, 1'b1, 1'b1, 1'b1, 2, 8'h03, 8'h01);
    u_bus.stop_msg();
    set_ctrl(1'b0, 1'b0, 1'b0, 1'b1, 7'h02);
    run(IAP_ROLE_SLAVE_RX, 1'b0, 1'b1, 1'b1, 1'b0, 1, 8'h00, 8'h00);
    u_bus.stop_msg();
    // An early stop leaves the final-byte NACK unissued; the next message restarts.
    set_ctrl(1'b1, 1'b0, 1'b1, 1'b1, 7'h03);
    run(IAP_ROLE_SLAVE_RX, 1'b1, 1'b0, 1'b1, 1'b1, 1, 8'h01, 8'h01);
    u_bus.stop_msg();
    run(IAP_ROLE_SLAVE_RX, 1'b1, 1'b0, 1'b1, 1'b1, 3, 8'h07, 8'h03);
    u_bus.stop_msg();
    // Invalid counts: zero and one above the buffer size.
    set_ctrl(1'b0, 1'b0, 1'b0, 1'b1, IAP_CNT_ZERO);
    check_irq(1'b1);
    check_bit(transfer_enable, 1'b0);
    check_byte(status_code, IAP_STAT_BAD_CNT);
    set_ctrl(1'b1, 1'b0, 1'b0, 1'b1, 7'h45);
    check_irq(1'b1);
    check_bit(transfer_enable, 1'b0);
    // Clock enable low: a valid write and a whole address slot must leave no trace.
    clk_en = 1'b0;
    set_ctrl(1'b1, 1'b0, 1'b0, 1'b0, 7'h00);
    check_bit(transfer_enable, 1'b0);
    u_bus.start_msg(IAP_ROLE_SLAVE_RX);
    u_bus.slot(1'b1, 1'b1, 1'b0);
    check_ack(1'b0, 1'b0);
    check_bit(addressed, 1'b0);
    clk_en = 1'b1;
    report_and_stop();
  end
endmodule
`default_nettype wire
